// ### src/decimation_chain.v
// Notes on behaviour
// - path code 00 bypass, 01 sinc, 10 sinc+fir, 11 adds high-pass
// - three cascaded stages: sinc, fir with phase choice, high-pass
// - sinc takes one modulator sample per modulator clock, master/4
// - fifth-order comb, unity dc gain via shift by 5*log2(N)
// - rate code 000..100 gives sinc ratio 128,64,32,16,8
// - fir has four sub-stages decimating by 2, 2, 4 and 2
// - sinc plus fir decimates 4096 down to 256
// - sub-stages three and four pick weights by phase select
// - fir passband flat to 0.375 of output rate, tight ripple
// - sinc response has zeros at its output rate and multiples
// - after sync, next modulator clock rise three master clocks on
// - bypass bit stream stable within 16 modulator clocks of sync
// - linear phase fir has constant delay for all frequencies
// - both fir variants share dc gain only, magnitude and phase differ
// - linear and minimum phase settle alike, outputs on the same cycles
// - bypass mode holds the digital filter shut down
// - phase select 0 is linear phase, 1 is minimum phase
// - merge streams: 3a2-6a3+4a4+9(b0-2b1+b2) before filtering
// - bypass drives modulator bit clock at master clock / 4
`timescale 1ns/1ps
`include "chain_consts.vh"

module sample_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output reg out_valid,
  input wire out_ready,
  output reg [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wp_reg;
  reg [AW-1:0] rp_reg;
  localparam [AW:0] FULL_CNT = DEPTH;
  reg [AW:0] cnt_reg;
  wire push;
  wire pop;

  assign in_ready = (cnt_reg != FULL_CNT);
  assign push = in_valid && in_ready;
  assign pop = (!out_valid || out_ready) && (cnt_reg != {(AW+1){1'b0}});

  always @(posedge clk) begin
    if (ce && push) begin
      mem[wp_reg] <= in_data;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      wp_reg <= {AW{1'b0}};
      rp_reg <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
      out_valid <= 1'b0;
      out_data <= {WIDTH{1'b0}};
    end else if (ce) begin
      if (push) begin
        wp_reg <= wp_reg + 1'b1;
      end
      if (pop) begin
        out_data <= mem[rp_reg];
        rp_reg <= rp_reg + 1'b1;
      end
      if (!out_valid || out_ready) begin
        out_valid <= pop;
      end
      if (push && !pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (pop && !push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end
endmodule

module decimation_chain (
  // clock, reset, enable
  input wire CLK,
  input wire RST,
  input wire CE,
  // configuration
  input wire [1:0] FILTER_PATH_SELECT,
  input wire [2:0] DECIMATION_RATE_SELECT,
  input wire FIR_PHASE_SELECT,
  input wire [15:0] HPF_COEFF,
  // sync pin, asynchronous
  input wire SYNC,
  // modulator bit streams
  input wire FIRST_STAGE_IN,
  input wire SECOND_STAGE_IN,
  // bypass outputs, enables low while driven
  output reg MOD_CLK_OUT,
  output reg MOD_CLK_OE_N,
  output reg FIRST_STAGE_BITS,
  output reg FIRST_STAGE_OE_N,
  output reg SECOND_STAGE_BITS,
  output reg SECOND_STAGE_OE_N,
  // filtered sample stream
  output wire DATA_VALID,
  input wire DATA_READY,
  output wire [31:0] DATA_OUT
);
  reg sync_a_reg;
  reg sync_b_reg;
  reg sync_c_reg;
  reg [1:0] phase_reg;
  reg [1:0] path_prev_reg;
  reg [2:0] rate_prev_reg;
  reg [3:0] a_hist_reg;
  reg [1:0] b_hist_reg;
  reg [6:0] dec_cnt_reg;
  reg signed [`SINC_W-1:0] integ_reg [0:`SINC_ORDER-1];
  reg signed [`SINC_W-1:0] dly_reg [0:`SINC_ORDER-1];
  reg signed [`DATA_W-1:0] sinc_out_reg;
  reg sinc_v_reg;
  reg signed [`DATA_W-1:0] hp_x_reg;
  reg signed [`DATA_W-1:0] hp_y_reg;
  reg hp_v_reg;
  reg push_reg;
  reg [`DATA_W-1:0] push_data_reg;
  reg signed [7:0] merged;

  wire sync_pulse;
  wire [2:0] rate_eff;
  wire [2:0] rate_log;
  wire [5:0] sinc_shift;
  wire [6:0] dec_last;
  wire filter_en;
  wire cfg_change;
  wire clr;
  wire fifo_ready;
  wire tick;
  wire run_tick;
  wire dec_tick;
  wire signed [`SINC_W-1:0] cmb [0:`SINC_ORDER];
  wire signed [`SINC_W-1:0] sinc_scaled;
  wire signed [`DATA_W-1:0] fir_x [0:`FIR_STAGES];
  wire fir_v [0:`FIR_STAGES];
  wire signed [`DATA_W+`HPF_FRAC:0] hp_prod;
  wire signed [`DATA_W-1:0] hp_y_next;

  // only the second and third flops feed the edge detector
  assign sync_pulse = sync_b_reg && !sync_c_reg;

  always @(posedge CLK) begin
    if (RST) begin
      sync_a_reg <= 1'b0;
      sync_b_reg <= 1'b0;
      sync_c_reg <= 1'b0;
    end else if (CE) begin
      sync_a_reg <= SYNC;
      sync_b_reg <= sync_a_reg;
      sync_c_reg <= sync_b_reg;
    end
  end

  assign rate_eff = (DECIMATION_RATE_SELECT > `RATE_LAST_VALID) ?
                    `RATE_FALLBACK : DECIMATION_RATE_SELECT;
  assign rate_log = `RATE_LOG_MAX - rate_eff;
  assign dec_last = `RATE_CNT_FULL >> rate_eff;
  // shift of 5*log2(N) restores unity dc gain
  assign sinc_shift = {1'b0, rate_log, 2'b00} + {3'b000, rate_log};

  assign filter_en = (FILTER_PATH_SELECT != `PATH_BYPASS);
  assign cfg_change = (FILTER_PATH_SELECT != path_prev_reg) ||
                      (rate_eff != rate_prev_reg);
  // restart on path or rate change or sync
  assign clr = RST || cfg_change || sync_pulse || !filter_en;

  // stalls sampling while the output fifo has no room
  assign tick = CE && (phase_reg == `MOD_PHASE_TICK);
  assign run_tick = tick && filter_en && fifo_ready;

  always @(posedge CLK) begin
    if (RST) begin
      path_prev_reg <= `PATH_BYPASS;
      rate_prev_reg <= `RATE_FALLBACK;
      phase_reg <= `MOD_PHASE_TICK;
      MOD_CLK_OUT <= 1'b0;
      MOD_CLK_OE_N <= 1'b1;
      FIRST_STAGE_BITS <= 1'b0;
      FIRST_STAGE_OE_N <= 1'b1;
      SECOND_STAGE_BITS <= 1'b0;
      SECOND_STAGE_OE_N <= 1'b1;
    end else if (CE) begin
      path_prev_reg <= FILTER_PATH_SELECT;
      rate_prev_reg <= rate_eff;
      // divider restarts so rise lands three clocks on
      if (sync_pulse) begin
        phase_reg <= `MOD_PHASE_TICK;
      end else begin
        phase_reg <= phase_reg + `MOD_PHASE_ONE;
      end
      // clock high for the upper half of the divider
      MOD_CLK_OUT <= sync_pulse ? 1'b0 : phase_reg[1];
      // bypass turns the stream pins into outputs
      MOD_CLK_OE_N <= filter_en;
      FIRST_STAGE_OE_N <= filter_en;
      SECOND_STAGE_OE_N <= filter_en;
      // bits follow the fresh divider from the first tick
      if (tick && !filter_en) begin
        FIRST_STAGE_BITS <= FIRST_STAGE_IN;
        SECOND_STAGE_BITS <= SECOND_STAGE_IN;
      end
    end
  end

  // merge of the two stage streams
  always @* begin
    merged = 8'sh00;
    if (a_hist_reg[1]) merged = merged + 8'sh03;
    if (a_hist_reg[2]) merged = merged - 8'sh06;
    if (a_hist_reg[3]) merged = merged + 8'sh04;
    if (SECOND_STAGE_IN) merged = merged + 8'sh09;
    if (b_hist_reg[0]) merged = merged - 8'sh12;
    if (b_hist_reg[1]) merged = merged + 8'sh09;
  end

  always @(posedge CLK) begin
    if (clr) begin
      a_hist_reg <= 4'h0;
      b_hist_reg <= 2'h0;
      dec_cnt_reg <= 7'h00;
    end else if (run_tick) begin
      a_hist_reg <= {a_hist_reg[2:0], FIRST_STAGE_IN};
      b_hist_reg <= {b_hist_reg[0], SECOND_STAGE_IN};
      dec_cnt_reg <= (dec_cnt_reg == dec_last) ? 7'h00 :
                     dec_cnt_reg + 7'h01;
    end
  end

  assign dec_tick = run_tick && (dec_cnt_reg == dec_last);

  // integrators at the modulator rate, combs at the output rate
  // N-sample comb puts zeros at the output rate and multiples
  assign cmb[0] = integ_reg[`SINC_ORDER-1];
  genvar gi;
  generate
    for (gi = 0; gi < `SINC_ORDER; gi = gi + 1) begin : g_sinc
      wire signed [`SINC_W-1:0] integ_in;
      if (gi == 0) begin : g_first
        assign integ_in = {{(`SINC_W-8){merged[7]}}, merged};
      end else begin : g_rest
        assign integ_in = integ_reg[gi-1];
      end
      assign cmb[gi+1] = cmb[gi] - dly_reg[gi];
      always @(posedge CLK) begin
        if (clr) begin
          integ_reg[gi] <= {`SINC_W{1'b0}};
          dly_reg[gi] <= {`SINC_W{1'b0}};
        end else begin
          if (run_tick) begin
            integ_reg[gi] <= integ_reg[gi] + integ_in;
          end
          if (dec_tick) begin
            dly_reg[gi] <= cmb[gi];
          end
        end
      end
    end
  endgenerate

  // wrap-around integrators are exact as long as combs see every sample
  assign sinc_scaled = cmb[`SINC_ORDER] >>> sinc_shift;

  always @(posedge CLK) begin
    if (clr) begin
      sinc_out_reg <= {`DATA_W{1'b0}};
      sinc_v_reg <= 1'b0;
    end else if (CE) begin
      sinc_v_reg <= dec_tick;
      if (dec_tick) begin
        sinc_out_reg <= sinc_scaled[`DATA_W-1:0];
      end
    end
  end

  // weights by sub-stage, index and phase
  // phase select 0 linear, 1 minimum
  function [3:0] fir_weight;
    input [1:0] stage;
    input [1:0] idx;
    input min_ph;
    begin
      fir_weight = `W_HALF;
      if (stage == 2'd2) begin
        if (!min_ph) begin
          // symmetric taps keep the delay constant
          fir_weight = (idx == 2'd0 || idx == 2'd3) ?
                       `W_LIN3_OUT : `W_LIN3_IN;
        end else begin
          case (idx)
            2'd0: fir_weight = `W_MIN3_0;
            2'd1: fir_weight = `W_MIN3_1;
            2'd2: fir_weight = `W_MIN3_2;
            default: fir_weight = `W_MIN3_3;
          endcase
        end
      end else if (stage == 2'd3) begin
        if (!min_ph) begin
          fir_weight = `W_LIN4;
        end else begin
          fir_weight = (idx == 2'd0) ? `W_MIN4_0 : `W_MIN4_1;
        end
      end
    end
  endfunction

  // fir fed by sinc output, high-pass fed by fir output
  assign fir_x[0] = sinc_out_reg;
  assign fir_v[0] = sinc_v_reg;

  // sub-stages decimate by 2, 2, 4, 2
  // fir adds a fixed factor 32 to the sinc ratio
  // weights of both variants sum alike, so dc gain matches
  // passband shape is set by the tap values alone
  generate
    for (gi = 0; gi < `FIR_STAGES; gi = gi + 1) begin : g_fir
      localparam [1:0] STAGE_NUM = gi;
      reg signed [`FIR_ACC_W-1:0] acc_reg;
      reg [1:0] idx_reg;
      reg signed [`DATA_W-1:0] out_reg;
      reg v_reg;
      wire [1:0] last;
      wire [5:0] shift;
      wire [3:0] w;
      wire signed [`FIR_ACC_W-1:0] term;
      wire signed [`FIR_ACC_W-1:0] sum;
      wire signed [`FIR_ACC_W-1:0] scaled;
      assign last = (gi == 2) ? `LAST_DEC4 : `LAST_DEC2;
      assign shift = (gi == 2) ? `SH_DEC4 :
                     (gi == 3) ? `SH_DEC2 : `SH_HALF;
      assign w = fir_weight(STAGE_NUM, idx_reg, FIR_PHASE_SELECT);
      assign term = fir_x[gi] * $signed({1'b0, w});
      assign sum = acc_reg + term;
      assign scaled = sum >>> shift;
      assign fir_x[gi+1] = out_reg;
      assign fir_v[gi+1] = v_reg;
      always @(posedge CLK) begin
        if (clr) begin
          acc_reg <= {`FIR_ACC_W{1'b0}};
          idx_reg <= 2'h0;
          out_reg <= {`DATA_W{1'b0}};
          v_reg <= 1'b0;
        end else if (CE) begin
          v_reg <= 1'b0;
          if (fir_v[gi]) begin
            if (idx_reg == last) begin
              out_reg <= scaled[`DATA_W-1:0];
              v_reg <= 1'b1;
              acc_reg <= {`FIR_ACC_W{1'b0}};
              idx_reg <= 2'h0;
            end else begin
              acc_reg <= sum;
              idx_reg <= idx_reg + 2'h1;
            end
          end
        end
      end
    end
  endgenerate

  // first-order high-pass: y = x - x1 + y1 - y1*k/2^16
  assign hp_prod = hp_y_reg * $signed({1'b0, HPF_COEFF});
  assign hp_y_next = fir_x[`FIR_STAGES] - hp_x_reg + hp_y_reg -
                     hp_prod[`DATA_W+`HPF_FRAC-1:`HPF_FRAC];

  always @(posedge CLK) begin
    if (clr) begin
      hp_x_reg <= {`DATA_W{1'b0}};
      hp_y_reg <= {`DATA_W{1'b0}};
      hp_v_reg <= 1'b0;
    end else if (CE) begin
      hp_v_reg <= fir_v[`FIR_STAGES];
      if (fir_v[`FIR_STAGES]) begin
        hp_x_reg <= fir_x[`FIR_STAGES];
        hp_y_reg <= hp_y_next;
      end
    end
  end

  always @(posedge CLK) begin
    if (clr) begin
      push_reg <= 1'b0;
      push_data_reg <= {`DATA_W{1'b0}};
    end else if (CE) begin
      case (FILTER_PATH_SELECT)
        `PATH_SINC: begin
          push_reg <= sinc_v_reg;
          push_data_reg <= sinc_out_reg;
        end
        `PATH_FIR: begin
          push_reg <= fir_v[`FIR_STAGES];
          push_data_reg <= fir_x[`FIR_STAGES];
        end
        `PATH_HPF: begin
          push_reg <= hp_v_reg;
          push_data_reg <= hp_y_reg;
        end
        default: begin
          push_reg <= 1'b0;
          push_data_reg <= {`DATA_W{1'b0}};
        end
      endcase
    end
  end

  sample_fifo #(
    .WIDTH(`DATA_W),
    .DEPTH(`FIFO_DEPTH),
    .AW(`FIFO_AW)
  ) u_fifo (
    .clk(CLK),
    .rst(RST),
    .ce(CE),
    .in_valid(push_reg),
    .in_ready(fifo_ready),
    .in_data(push_data_reg),
    .out_valid(DATA_VALID),
    .out_ready(DATA_READY),
    .out_data(DATA_OUT)
  );
endmodule

// ### src/chain_consts.vh
`ifndef CHAIN_CONSTS_VH
`define CHAIN_CONSTS_VH

// output path codes
`define PATH_BYPASS 2'b00
`define PATH_SINC 2'b01
`define PATH_FIR 2'b10
`define PATH_HPF 2'b11

// decimation rate codes
`define RATE_LAST_VALID 3'h4
`define RATE_FALLBACK 3'h0
`define RATE_LOG_MAX 3'h7
`define RATE_CNT_FULL 7'h7f

// modulator clock divider (master clock / 4)
`define MOD_PHASE_TICK 2'h0
`define MOD_PHASE_ONE 2'h1

// datapath widths and depths
`define DATA_W 32
`define SINC_W 42
`define SINC_ORDER 5
`define FIR_STAGES 4
`define FIR_ACC_W 40
`define FIFO_DEPTH 16
`define FIFO_AW 4

// high-pass coefficient fraction bits
`define HPF_FRAC 16

// fir sub-stage weights, index last, and normalising shifts
`define W_HALF 4'h1
`define W_LIN3_OUT 4'h1
`define W_LIN3_IN 4'h3
`define W_MIN3_0 4'h4
`define W_MIN3_1 4'h2
`define W_MIN3_2 4'h1
`define W_MIN3_3 4'h1
`define W_LIN4 4'h2
`define W_MIN4_0 4'h3
`define W_MIN4_1 4'h1
`define LAST_DEC2 2'h1
`define LAST_DEC4 2'h3
`define SH_HALF 6'h1
`define SH_DEC4 6'h3
`define SH_DEC2 6'h2

`endif

// ### sim/chain_assertions.sv
`timescale 1ns/1ps
`include "chain_consts.vh"
module chain_assertions (
  // clock and reset
  input wire CLK,
  input wire RST,
  // configuration and sync
  input wire [1:0] FILTER_PATH_SELECT,
  input wire SYNC,
  // bypass pins
  input wire MOD_CLK_OUT,
  input wire MOD_CLK_OE_N,
  input wire FIRST_STAGE_BITS,
  input wire FIRST_STAGE_OE_N,
  input wire SECOND_STAGE_OE_N,
  // sample stream
  input wire DATA_VALID,
  input wire DATA_READY,
  input wire [31:0] DATA_OUT
);
  reg [2:0] quiet_reg;
  reg [5:0] idle_reg;
  wire byp = FILTER_PATH_SELECT == `PATH_BYPASS;
  // a sync still in the two flops may reset the divider phase
  always @(posedge CLK) begin
    if (RST || SYNC) quiet_reg <= 3'h0;
    else if (quiet_reg != 3'h7) quiet_reg <= quiet_reg + 3'h1;
    if (RST || !byp || !DATA_READY) idle_reg <= 6'h0;
    else if (idle_reg != 6'h3f) idle_reg <= idle_reg + 6'h1;
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  sequence high_half;
    MOD_CLK_OUT [*2];
  endsequence
  sequence low_half;
    !MOD_CLK_OUT [*2];
  endsequence
  reset_release_a: assert property ($fell(RST) |-> !DATA_VALID &&
    !MOD_CLK_OUT && MOD_CLK_OE_N && FIRST_STAGE_OE_N && SECOND_STAGE_OE_N)
    else $error("outputs not idle after reset");
  mclk_period_a: assert property (@(posedge CLK) disable iff (RST || SYNC)
    $rose(MOD_CLK_OUT) && byp && quiet_reg == 3'h7 |->
    high_half ##1 low_half ##1 MOD_CLK_OUT)
    else $error("modulator clock not a quarter of master");
  sync_restart_a: assert property (byp && $rose(SYNC) |->
    ##3 !MOD_CLK_OUT [*3] ##1 MOD_CLK_OUT)
    else $error("modulator clock not realigned by sync");
  bits_hold_a: assert property (@(posedge CLK)
    disable iff (RST || SYNC || !byp)
    quiet_reg == 3'h7 && $changed(FIRST_STAGE_BITS) |=>
    $stable(FIRST_STAGE_BITS) [*3])
    else $error("bypass bit not held a modulator period");
  oe_driven_a: assert property (byp [*3] |-> !MOD_CLK_OE_N &&
    !FIRST_STAGE_OE_N && !SECOND_STAGE_OE_N)
    else $error("bypass pins not driven");
  oe_released_a: assert property (!byp [*3] |-> MOD_CLK_OE_N &&
    FIRST_STAGE_OE_N && SECOND_STAGE_OE_N)
    else $error("bypass pins driven outside bypass");
  filter_idle_a: assert property (idle_reg > 6'h28 |-> !DATA_VALID)
    else $error("samples produced in bypass");
  data_hold_a: assert property (DATA_VALID && !DATA_READY &&
    $stable(FILTER_PATH_SELECT) |=> DATA_VALID && $stable(DATA_OUT))
    else $error("offered sample dropped or changed");
endmodule

// ### sim/mod_source.sv
`timescale 1ns/1ps
module mod_source (
  // clock and stream choice
  input wire clk,
  input wire [1:0] mode,
  // modulator bits
  output reg a_bit,
  output reg b_bit
);
  initial {a_bit, b_bit} = 2'h0;
  always @(posedge clk) begin
    #1;
    case (mode)
      2'h0: {a_bit, b_bit} <= 2'h0;
      2'h1: {a_bit, b_bit} <= 2'h2;
      2'h2: {a_bit, b_bit} <= 2'h3;
      default: {a_bit, b_bit} <= $urandom % 4;
    endcase
  end
endmodule

// ### sim/decimation_chain_tb.sv
`timescale 1ns/1ps
`include "chain_consts.vh"
module decimation_chain_tb;
  reg CLK, RST, CE, SYNC, DATA_READY, FIR_PHASE_SELECT;
  reg [1:0] FILTER_PATH_SELECT, mode;
  reg [2:0] DECIMATION_RATE_SELECT;
  reg [15:0] HPF_COEFF;
  wire a_bit, b_bit, DATA_VALID, MOD_CLK_OUT, MOD_CLK_OE_N;
  wire FIRST_STAGE_BITS, FIRST_STAGE_OE_N, SECOND_STAGE_BITS;
  wire SECOND_STAGE_OE_N;
  wire [31:0] DATA_OUT;
  logic [31:0] w;
  integer fail_count = 0, num_checks = 0, gap, cnt, i, seed;
  decimation_chain u_dut (.CLK(CLK), .RST(RST), .CE(CE),
    .FILTER_PATH_SELECT(FILTER_PATH_SELECT),
    .DECIMATION_RATE_SELECT(DECIMATION_RATE_SELECT),
    .FIR_PHASE_SELECT(FIR_PHASE_SELECT), .HPF_COEFF(HPF_COEFF),
    .SYNC(SYNC), .FIRST_STAGE_IN(a_bit), .SECOND_STAGE_IN(b_bit),
    .MOD_CLK_OUT(MOD_CLK_OUT), .MOD_CLK_OE_N(MOD_CLK_OE_N),
    .FIRST_STAGE_BITS(FIRST_STAGE_BITS),
    .FIRST_STAGE_OE_N(FIRST_STAGE_OE_N),
    .SECOND_STAGE_BITS(SECOND_STAGE_BITS),
    .SECOND_STAGE_OE_N(SECOND_STAGE_OE_N), .DATA_VALID(DATA_VALID),
    .DATA_READY(DATA_READY), .DATA_OUT(DATA_OUT));
  mod_source u_src (.clk(CLK), .mode(mode), .a_bit(a_bit), .b_bit(b_bit));
  task report_and_stop;
    if (fail_count == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task check(input string what, input logic [31:0] seen, exp);
    num_checks = num_checks + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge CLK);
    #1;
  endtask
  // takes one word; gap is edges since the previous take
  task next_word;
    gap = 1;
    while (DATA_VALID !== 1'b1 && gap < 9000) begin
      tick(1);
      gap = gap + 1;
    end
    if (gap >= 9000) begin
      fail_count = fail_count + 1;
      report_and_stop;
    end
    w = DATA_OUT;
    tick(1);
  endtask
  task settle(input [1:0] p, input [2:0] r, input integer skip);
    FILTER_PATH_SELECT = p;
    DECIMATION_RATE_SELECT = r;
    repeat (skip) next_word;
  endtask
  function integer spacing(input [1:0] p, input [2:0] r);
    spacing = 4 * ((r > 3'h4) ? 128 : (128 >> r));
    if (p != `PATH_SINC) spacing = spacing * 32;
  endfunction
  initial begin
    CLK = 0;
    forever #10 CLK = ~CLK;
  end
  initial begin
    RST = 1; CE = 1; SYNC = 0; DATA_READY = 1; FIR_PHASE_SELECT = 0;
    FILTER_PATH_SELECT = `PATH_SINC; DECIMATION_RATE_SELECT = 3'h4;
    mode = 2'h1;
    seed = $urandom(86);
    HPF_COEFF = $urandom;
    tick(4);
    RST = 0;
    for (i = 0; i < 8; i = i + 1) begin
      settle(`PATH_SINC, i, 7);
      next_word;
      check("sinc gap", gap, spacing(`PATH_SINC, i));
      check("sinc dc", w, 32'h1);
    end
    mode = 2'h0;
    settle(`PATH_SINC, 3'h4, 0);
    repeat (8) begin
      next_word;
      check("clean change", w <= 32'h1, 32'h1);
    end
    check("sinc zero", w, 32'h0);
    mode = 2'h2;
    for (i = 0; i < 3; i = i + 1) begin
      FIR_PHASE_SELECT = i[0];
      settle((i < 2) ? `PATH_FIR : `PATH_HPF, 3'h4, 6);
      next_word;
      check("fir gap", gap, spacing(`PATH_FIR, 3'h4));
      if (i < 2) check("fir dc", w, 32'h1);
    end
    settle(`PATH_SINC, 3'h4, 7);
    DATA_READY = 0;
    tick(1400);
    DATA_READY = 1;
    cnt = 0;
    gap = 1;
    while (gap == 1 && cnt < 40) begin
      next_word;
      if (gap == 1) begin
        cnt = cnt + 1;
        check("held word", w, 32'h1);
      end
    end
    check("fifo depth", cnt >= 16 && cnt <= 18, 32'h1);
    mode = 2'h3;
    repeat (5) next_word;
    repeat (20) begin
      next_word;
      check("bounded", $signed(w) <= 25 && $signed(w) >= -25, 1);
    end
    mode = 2'h1;
    FILTER_PATH_SELECT = `PATH_BYPASS;
    tick(60);
    check("clock pin", MOD_CLK_OE_N, 32'h0);
    check("filter off", DATA_VALID, 32'h0);
    for (i = 0; i < 4; i = i + 1) begin
      tick($urandom % 7 + 5);
      SYNC = 1;
      tick(4);
      SYNC = 0;
      tick(64);
      check("bit pins", {FIRST_STAGE_OE_N, SECOND_STAGE_OE_N}, 0);
      check("bit values", {FIRST_STAGE_BITS, SECOND_STAGE_BITS}, 2);
    end
    FILTER_PATH_SELECT = `PATH_SINC;
    tick(4);
    check("released", {MOD_CLK_OE_N, FIRST_STAGE_OE_N}, 32'h3);
    report_and_stop;
  end
endmodule
bind decimation_chain chain_assertions u_chk (.CLK(CLK), .RST(RST),
  .FILTER_PATH_SELECT(FILTER_PATH_SELECT), .SYNC(SYNC),
  .MOD_CLK_OUT(MOD_CLK_OUT), .MOD_CLK_OE_N(MOD_CLK_OE_N),
  .FIRST_STAGE_BITS(FIRST_STAGE_BITS), .FIRST_STAGE_OE_N(FIRST_STAGE_OE_N),
  .SECOND_STAGE_OE_N(SECOND_STAGE_OE_N), .DATA_VALID(DATA_VALID),
  .DATA_READY(DATA_READY), .DATA_OUT(DATA_OUT));
